/* pkg/charger_i2c_pkg.sv */
package charger_i2c_pkg;
	// Slave addresses, seven bits without the direction bit, then the high-speed master code
	localparam logic [6:0] SLAVE_ADDR_MAIN     = 7'h6B;
	localparam logic [6:0] SLAVE_ADDR_ALT      = 7'h6A;
	localparam logic [4:0] HS_CODE_TOP         = 5'h01;
	localparam logic [7:0] HS_MASTER_CODE      = 8'h08;

	localparam logic [7:0] REG_STATUS_CONTROL  = 8'h00;
	localparam logic [7:0] REG_CHARGE_CONTROL  = 8'h01;
	localparam logic [7:0] REG_FLOAT_VOLTAGE   = 8'h02;
	localparam logic [7:0] REG_DEVICE_IDENTITY = 8'h03;
	localparam logic [7:0] REG_BATTERY_CURRENT = 8'h04;
	localparam logic [7:0] REG_SPECIAL_CHARGER = 8'h05;
	localparam logic [7:0] REG_SAFETY_LIMITS   = 8'h06;
	localparam logic [7:0] REG_LIVE_STATUS     = 8'h10;

	localparam logic [7:0] CHARGE_CONTROL_RST  = 8'h30;
	localparam logic [7:0] FLOAT_VOLTAGE_RST   = 8'h0A;
	localparam logic [7:0] BATTERY_CURRENT_RST = 8'h00;
	localparam logic [7:0] SPECIAL_CHARGER_RST = 8'h00;
	localparam logic [7:0] SAFETY_LIMITS_RST   = 8'h00;
	localparam logic       STAT_ENABLE_RST     = 1'b1;
	// Arbitrary identity value
	localparam logic [7:0] DEVICE_IDENTITY_VAL = 8'h5A;
	localparam logic [7:0] UNMAPPED_READ       = 8'h00;

	localparam int TIMER_RESET_BIT = 7;
	localparam int STAT_ENABLE_BIT = 6;
	localparam int TE_BIT          = 3;
	localparam int HZ_BIT          = 1;

	localparam int MCLK_NS         = 10;
	localparam int FS_KHZ          = 400;
	localparam int HS_MAX_MHZ_X10  = 34;
	localparam int FS_QUARTER_CYC  = (1000000 + 4 * FS_KHZ * MCLK_NS - 1) / (4 * FS_KHZ * MCLK_NS);
	localparam int HS_QUARTER_CYC  = (10000 + 4 * HS_MAX_MHZ_X10 * MCLK_NS - 1) / (4 * HS_MAX_MHZ_X10 * MCLK_NS);

	// Host command port
	localparam logic [2:0] HOST_CTRL       = 3'h0;
	localparam logic [2:0] HOST_REG        = 3'h1;
	localparam logic [2:0] HOST_WDATA      = 3'h2;
	localparam logic [2:0] HOST_STATUS     = 3'h3;
	localparam logic [2:0] HOST_RDATA      = 3'h4;
	localparam int         CTRL_GO_BIT     = 0;
	localparam int         CTRL_READ_BIT   = 1;
	localparam int         CTRL_HS_BIT     = 2;
	localparam int         CTRL_ALT_BIT    = 3;
endpackage : charger_i2c_pkg

/* pkg/charger_i2c_if.sv */
`timescale 1ns/1ps
interface charger_i2c_if;
	logic host_scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// SDA is an open-drain wire with pull-up, low while any enabled driver pulls low; SCL follows the host
	assign scl = host_scl;
	assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);

	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (output host_scl, input sda, output host_sda_o, output host_sda_oe);
endinterface : charger_i2c_if

/* logic/charger_i2c_device.sv */
`timescale 1ns/1ps
//
// Contract
// - SCL input only; SDA pulled low only
// - Bytes shifted MSB first
// - Answer only own seven-bit slave address
// - Sample SDA on SCL rising edge
// - Master changes SDA while SCL low
// - Idle bus has SCL, SDA high
// - SDA falling, SCL high is start
// - SDA rising, SCL high is stop
// - Read: register address, repeated start, read
// - Master code 00001XXX announced, never acknowledged
// - Repeated start after code enters high speed; hs_mode_o rises at the code byte's eighth bit
// - High speed lasts until stop
// - Acknowledge by driving SDA low
// - Decode 0-4, 10h, 5-6 when extended
// - Live status is unfiltered real time
// - Bits 3, 2, 0 loop states
// - Bit 5 shows linear charging
// - Termination and high-impedance select comparisons
module charger_i2c_device
	import charger_i2c_pkg::*;
#(
	parameter bit ALT_ADDRESS = 1'b0,
	parameter bit EXTENDED    = 1'b1
)(
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	charger_i2c_if.device   bus,
	input  wire logic       termination_compare_flag_i,
	input  wire logic       near_zero_compare_i,
	input  wire logic       short_compare_i,
	input  wire logic       low_battery_compare_i,
	input  wire logic       boost_uvlo_compare_i,
	input  wire logic       linear_charge_flag_i,
	input  wire logic       over_temp_flag_i,
	input  wire logic       charge_loop_flag_i,
	input  wire logic       input_limit_flag_i,
	input  wire logic       input_present_flag_i,
	input  wire logic       constant_voltage_flag_i,
	input  wire logic       boosting_i,
	input  wire logic       otg_level_i,
	input  wire logic [1:0] charge_state_i,
	input  wire logic       boost_active_i,
	input  wire logic [2:0] fault_i,
	output logic      [7:0] charge_control_o,
	output logic      [7:0] float_voltage_o,
	output logic      [7:0] battery_current_o,
	output logic      [7:0] special_charger_o,
	output logic      [7:0] safety_limits_o,
	output logic            stat_enable_o,
	output logic            timer_reset_o,
	output logic            hs_mode_o
);
	import charger_i2c_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_ADDR  = 4'h1,
		ST_AACK  = 4'h3,
		ST_REG   = 4'h2,
		ST_RACK  = 4'h6,
		ST_WDATA = 4'h7,
		ST_WACK  = 4'h5,
		ST_RDATA = 4'h4,
		ST_MACK  = 4'hC
	} dev_state_e;

	localparam int IN_W = 18;
	localparam logic [6:0] OWN_ADDR = ALT_ADDRESS ? SLAVE_ADDR_ALT : SLAVE_ADDR_MAIN;

	dev_state_e      state_r;
	logic [1:0]      link1_r;
	logic [1:0]      link2_r;
	logic [1:0]      link3_r;
	logic [1:0]      fault0_r;
	logic [IN_W-1:0] in1_r;
	logic [IN_W-1:0] in2_r;
	logic [2:0]      cnt_r;
	logic [6:0]      shift_r;
	logic [7:0]      tx_r;
	logic [7:0]      reg_ptr_r;
	logic            rw_r;
	logic            oe_r;
	logic            hs_r;
	logic            stat_en_r;
	logic            tmr_rst_r;
	logic [7:0]      chg_ctl_r;
	logic [7:0]      float_r;
	logic [7:0]      battery_current_r;
	logic [7:0]      special_r;
	logic [7:0]      safety_r;
	logic            scl_s;
	logic            sda_s;
	logic            scl_rise;
	logic            scl_fall;
	logic            start_det;
	logic            stop_det;
	logic [7:0]      rx_byte;
	logic            byte_done;
	logic            wr_en;
	logic [7:0]      live_status;
	logic [7:0]      read_val;

	// Pin and comparator synchronisers; stage one feeds stage two only
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			link1_r <= 2'h3;
			link2_r <= 2'h3;
			link3_r <= 2'h3;
		end
		else
		begin
			link1_r <= {bus.scl, bus.sda};
			link2_r <= link1_r;
			link3_r <= link2_r;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			in1_r <= '0;
			in2_r <= '0;
		end
		else
		begin
			in1_r <= {termination_compare_flag_i, near_zero_compare_i, short_compare_i, low_battery_compare_i,
				boost_uvlo_compare_i, linear_charge_flag_i, over_temp_flag_i, charge_loop_flag_i,
				input_limit_flag_i, input_present_flag_i, constant_voltage_flag_i, boosting_i,
				otg_level_i, charge_state_i, boost_active_i, fault_i[2:1]};
			in2_r <= in1_r;
		end
	end

	// Lowest fault bit gets its own two-stage chain so no pin reaches logic unsynchronised
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			fault0_r <= 2'h0;
		else
			fault0_r <= {fault0_r[0], fault_i[0]};
	end

	assign scl_s     = link2_r[1];
	assign sda_s     = link2_r[0];
	assign scl_rise  = scl_s && !link3_r[1];
	assign scl_fall  = !scl_s && link3_r[1];
	assign start_det = scl_s && link3_r[1] && link3_r[0] && !sda_s;
	assign stop_det  = scl_s && link3_r[1] && !link3_r[0] && sda_s;
	assign rx_byte   = {shift_r, sda_s};
	assign byte_done = scl_rise && (cnt_r == 3'h7);

	// Status mux follows the selects live; no filtering on purpose
	always_comb
	begin
		live_status    = 8'h00;
		live_status[7] = chg_ctl_r[TE_BIT] ? in2_r[17] : in2_r[16];
		if (chg_ctl_r[HZ_BIT])
			live_status[6] = in2_r[14];
		else if (in2_r[6])
			live_status[6] = in2_r[13];
		else
			live_status[6] = in2_r[15];
		live_status[5] = in2_r[12];
		live_status[4] = in2_r[11];
		live_status[3] = in2_r[10];
		live_status[2] = in2_r[9];
		live_status[1] = in2_r[8];
		live_status[0] = in2_r[7];
	end

	// Reads of unmapped or absent registers return a fixed value
	always_comb
	begin
		read_val = UNMAPPED_READ;
		unique case (reg_ptr_r)
			REG_STATUS_CONTROL:  read_val = {in2_r[5], stat_en_r, in2_r[4:3], in2_r[2], in2_r[1:0], fault0_r[1]};
			REG_CHARGE_CONTROL:  read_val = chg_ctl_r;
			REG_FLOAT_VOLTAGE:   read_val = float_r;
			REG_DEVICE_IDENTITY: read_val = DEVICE_IDENTITY_VAL;
			REG_BATTERY_CURRENT: read_val = battery_current_r;
			REG_SPECIAL_CHARGER: read_val = EXTENDED ? special_r : UNMAPPED_READ;
			REG_SAFETY_LIMITS:   read_val = EXTENDED ? safety_r : UNMAPPED_READ;
			REG_LIVE_STATUS:     read_val = live_status;
			default:             read_val = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			state_r   <= ST_IDLE;
			cnt_r     <= 3'h0;
			shift_r   <= 7'h00;
			rw_r      <= 1'b0;
			reg_ptr_r <= 8'h00;
			tx_r      <= 8'h00;
		end
		else if (start_det)
		begin
			state_r <= ST_ADDR;
			cnt_r   <= 3'h0;
		end
		else if (stop_det)
			state_r <= ST_IDLE;
		else if (scl_rise)
		begin
			shift_r <= rx_byte[6:0];
			cnt_r   <= cnt_r + 3'h1;
			unique case (state_r)
				ST_IDLE:
					cnt_r <= 3'h0;
				ST_ADDR:
					if (byte_done)
					begin
						if (rx_byte[7:1] == OWN_ADDR)
						begin
							rw_r    <= rx_byte[0];
							state_r <= ST_AACK;
						end
						else
							state_r <= ST_IDLE;
					end
				ST_AACK:
				begin
					cnt_r <= 3'h0;
					if (rw_r)
					begin
						tx_r    <= read_val;
						state_r <= ST_RDATA;
					end
					else
						state_r <= ST_REG;
				end
				ST_REG:
					if (byte_done)
					begin
						reg_ptr_r <= rx_byte;
						state_r   <= ST_RACK;
					end
				ST_RACK, ST_WACK:
				begin
					cnt_r   <= 3'h0;
					state_r <= ST_WDATA;
				end
				ST_WDATA:
					if (byte_done)
						state_r <= ST_WACK;
				ST_RDATA:
					if (byte_done)
						state_r <= ST_MACK;
				ST_MACK:
				begin
					cnt_r <= 3'h0;
					if (!sda_s)
					begin
						tx_r    <= read_val;
						state_r <= ST_RDATA;
					end
					else
						state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Drive changes only after SCL falls, apart from release at a start or stop, so a start or stop is never faked
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			oe_r <= 1'b0;
		else if (start_det || stop_det)
			oe_r <= 1'b0;
		else if (scl_fall)
			oe_r <= (state_r == ST_AACK) || (state_r == ST_RACK) || (state_r == ST_WACK) ||
				((state_r == ST_RDATA) && !tx_r[3'h7 - cnt_r]);
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			hs_r <= 1'b0;
		else if (stop_det)
			hs_r <= 1'b0;
		else if (state_r == ST_ADDR && byte_done && rx_byte[7:3] == HS_CODE_TOP)
			hs_r <= 1'b1;
	end

	assign wr_en = scl_rise && (state_r == ST_WDATA) && (cnt_r == 3'h7) && !start_det && !stop_det;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			chg_ctl_r <= CHARGE_CONTROL_RST;
			float_r   <= FLOAT_VOLTAGE_RST;
			battery_current_r    <= BATTERY_CURRENT_RST;
			special_r <= SPECIAL_CHARGER_RST;
			safety_r  <= SAFETY_LIMITS_RST;
			stat_en_r <= STAT_ENABLE_RST;
			tmr_rst_r <= 1'b0;
		end
		else
		begin
			tmr_rst_r <= 1'b0;
			if (wr_en)
			begin
				unique case (reg_ptr_r)
					REG_STATUS_CONTROL:
					begin
						tmr_rst_r <= rx_byte[TIMER_RESET_BIT];
						stat_en_r <= rx_byte[STAT_ENABLE_BIT];
					end
					REG_CHARGE_CONTROL:  chg_ctl_r <= rx_byte;
					REG_FLOAT_VOLTAGE:   float_r   <= rx_byte;
					REG_BATTERY_CURRENT: battery_current_r    <= rx_byte;
					REG_SPECIAL_CHARGER: special_r <= EXTENDED ? rx_byte : special_r;
					REG_SAFETY_LIMITS:   safety_r  <= EXTENDED ? rx_byte : safety_r;
					default:             ;
				endcase
			end
		end
	end

	assign bus.dev_sda_o  = 1'b0;
	assign bus.dev_sda_oe = oe_r;
	assign charge_control_o  = chg_ctl_r;
	assign float_voltage_o   = float_r;
	assign battery_current_o = battery_current_r;
	assign special_charger_o = special_r;
	assign safety_limits_o   = safety_r;
	assign stat_enable_o     = stat_en_r;
	assign timer_reset_o     = tmr_rst_r;
	assign hs_mode_o         = hs_r;
endmodule : charger_i2c_device

/* logic/charger_i2c_host.sv */
`timescale 1ns/1ps
module charger_i2c_host
	import charger_i2c_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	charger_i2c_if.host     bus,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o
);
	import charger_i2c_pkg::*;

	typedef enum logic [1:0] {K_START = 2'h0, K_TX = 2'h1, K_RX = 2'h3, K_STOP = 2'h2} kind_e;

	logic       sda1_r;
	logic       sda2_r;
	logic       busy_r;
	logic       nack_r;
	logic       op_read_r;
	logic       op_hs_r;
	logic       op_alt_r;
	logic       hs_act_r;
	logic [7:0] reg_r;
	logic [7:0] wdata_r;
	logic [7:0] rxd_r;
	logic [6:0] qcnt_r;
	logic [1:0] q_r;
	logic [3:0] step_r;
	logic [3:0] bit_r;
	logic       scl_r;
	logic       sda_lvl_r;
	logic [7:0] rdata_r;
	logic       tick;
	logic [3:0] n;
	kind_e      kind;
	logic [7:0] tx_byte;
	logic [6:0] own;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			sda1_r <= 1'b1;
			sda2_r <= 1'b1;
		end
		else
		begin
			sda1_r <= bus.sda;
			sda2_r <= sda1_r;
		end
	end

	assign tick = busy_r && (qcnt_r == 7'h00);
	assign own  = op_alt_r ? SLAVE_ADDR_ALT : SLAVE_ADDR_MAIN;
	assign n    = op_hs_r ? step_r - 4'h2 : step_r;

	// Step list: optional master code, then the documented packet order
	always_comb
	begin
		kind    = K_STOP;
		tx_byte = HS_MASTER_CODE;
		if (op_hs_r && step_r == 4'h0)
			kind = K_START;
		else if (op_hs_r && step_r == 4'h1)
			kind = K_TX;
		else
			unique case (n)
				4'h0:    kind = K_START;
				4'h1:
				begin
					kind    = K_TX;
					tx_byte = {own, 1'b0};
				end
				4'h2:
				begin
					kind    = K_TX;
					tx_byte = reg_r;
				end
				4'h3:
				begin
					kind    = op_read_r ? K_START : K_TX;
					tx_byte = op_read_r ? 8'h00 : wdata_r;
				end
				4'h4:
				begin
					kind    = op_read_r ? K_TX : K_STOP;
					tx_byte = op_read_r ? {own, 1'b1} : 8'h00;
				end
				4'h5:    kind = op_read_r ? K_RX : K_STOP;
				default: kind = K_STOP;
			endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			busy_r    <= 1'b0;
			nack_r    <= 1'b0;
			op_read_r <= 1'b0;
			op_hs_r   <= 1'b0;
			op_alt_r  <= 1'b0;
			hs_act_r  <= 1'b0;
			reg_r     <= 8'h00;
			wdata_r   <= 8'h00;
			rxd_r     <= 8'h00;
			qcnt_r    <= 7'h00;
			q_r       <= 2'h0;
			step_r    <= 4'h0;
			bit_r     <= 4'h0;
			scl_r     <= 1'b1;
			sda_lvl_r <= 1'b1;
		end
		else if (!busy_r)
		begin
			scl_r     <= 1'b1;
			sda_lvl_r <= 1'b1;
			if (wr_i && addr_i == HOST_REG)
				reg_r <= wdata_i;
			if (wr_i && addr_i == HOST_WDATA)
				wdata_r <= wdata_i;
			if (wr_i && addr_i == HOST_CTRL && wdata_i[CTRL_GO_BIT])
			begin
				busy_r    <= 1'b1;
				nack_r    <= 1'b0;
				op_read_r <= wdata_i[CTRL_READ_BIT];
				op_hs_r   <= wdata_i[CTRL_HS_BIT];
				op_alt_r  <= wdata_i[CTRL_ALT_BIT];
				q_r       <= 2'h0;
				step_r    <= 4'h0;
				bit_r     <= 4'h0;
				qcnt_r    <= 7'(FS_QUARTER_CYC - 1);
			end
		end
		else
		begin
			qcnt_r <= qcnt_r - 7'h01;
			if (tick)
			begin
				qcnt_r <= hs_act_r ? 7'(HS_QUARTER_CYC - 1) : 7'(FS_QUARTER_CYC - 1);
				q_r    <= q_r + 2'h1;
				unique case (kind)
					K_START:
						unique case (q_r)
							2'h0:    {scl_r, sda_lvl_r} <= 2'b01;
							2'h1:    scl_r <= 1'b1;
							2'h2:    sda_lvl_r <= 1'b0;
							default: scl_r <= 1'b0;
						endcase
					K_STOP:
						unique case (q_r)
							2'h0:    {scl_r, sda_lvl_r} <= 2'b00;
							2'h1:    scl_r <= 1'b1;
							2'h2:    sda_lvl_r <= 1'b1;
							default:
							begin
								busy_r   <= 1'b0;
								hs_act_r <= 1'b0;
							end
						endcase
					default:
						unique case (q_r)
							2'h0:
							begin
								scl_r     <= 1'b0;
								sda_lvl_r <= (kind == K_TX && bit_r < 4'h8) ? tx_byte[3'(4'h7 - bit_r)] : 1'b1;
							end
							2'h1:    ;
							2'h2:    scl_r <= 1'b1;
							default:
							begin
								if (kind == K_RX && bit_r < 4'h8)
									rxd_r <= {rxd_r[6:0], sda2_r};
								if (kind == K_TX && bit_r == 4'h8 && sda2_r && !(op_hs_r && step_r == 4'h1))
									nack_r <= 1'b1;
							end
						endcase
				endcase
				if (q_r == 2'h3)
				begin
					if (kind == K_START || ((kind == K_TX || kind == K_RX) && bit_r == 4'h8))
					begin
						step_r <= step_r + 4'h1;
						bit_r  <= 4'h0;
						if (op_hs_r && step_r == 4'h1)
							hs_act_r <= 1'b1;
					end
					else if (kind != K_STOP)
						bit_r <= bit_r + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			rdata_r <= 8'h00;
		else if (rd_i)
			unique case (addr_i)
				HOST_CTRL:   rdata_r <= {4'h0, op_alt_r, op_hs_r, op_read_r, busy_r};
				HOST_REG:    rdata_r <= reg_r;
				HOST_WDATA:  rdata_r <= wdata_r;
				HOST_STATUS: rdata_r <= {5'h00, hs_act_r, nack_r, busy_r};
				HOST_RDATA:  rdata_r <= rxd_r;
				default:     rdata_r <= 8'h00;
			endcase
		else
			rdata_r <= 8'h00;
	end

	assign rdata_o          = rdata_r;
	assign bus.host_scl     = scl_r;
	assign bus.host_sda_o   = 1'b0;
	assign bus.host_sda_oe  = !sda_lvl_r;
endmodule : charger_i2c_host

/* dv/charger_i2c_properties.sv */
`timescale 1ns/1ps
module charger_i2c_properties
	import charger_i2c_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic dev_sda_o,
	input  wire logic dev_sda_oe
);
	logic       scl_q_r;
	logic       sda_q_r;
	logic       first_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic       rise;
	logic       start_seen;
	logic       stop_seen;

	assign rise       = scl && !scl_q_r;
	assign start_seen = scl && scl_q_r && sda_q_r && !sda;
	assign stop_seen  = scl && scl_q_r && !sda_q_r && sda;

	always_ff @(posedge mclk_i)
	begin
		scl_q_r <= rst_n_i ? scl : 1'b1;
		sda_q_r <= rst_n_i ? sda : 1'b1;
	end

	// Only the first byte after any start is an address; later bytes are data
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			bit_cnt_r <= 4'h0;
			first_r   <= 1'b0;
			shift_r   <= 8'h00;
		end
		else if (start_seen)
		begin
			bit_cnt_r <= 4'h0;
			first_r   <= 1'b1;
		end
		else if (rise && bit_cnt_r == 4'h8)
		begin
			bit_cnt_r <= 4'h0;
			first_r   <= 1'b0;
		end
		else if (rise)
		begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			shift_r   <= {shift_r[6:0], sda};
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_pull_low;
		dev_sda_oe |-> !dev_sda_o;
	endproperty
	a_pull_low: assert property (p_pull_low)
		else $error("device drives sda high");

	property p_change_scl_low;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_change_scl_low: assert property (p_change_scl_low)
		else $error("device sda changed while scl high");

	property p_drive_after_fall;
		$rose(dev_sda_oe) |-> !scl && $past(scl, 6);
	endproperty
	a_drive_after_fall: assert property (p_drive_after_fall)
		else $error("device pull not tied to scl fall");

	property p_ack_level;
		rise && dev_sda_oe |-> !sda;
	endproperty
	a_ack_level: assert property (p_ack_level)
		else $error("sda not low at sampled pull");

	property p_start_free;
		start_seen |-> !dev_sda_oe;
	endproperty
	a_start_free: assert property (p_start_free)
		else $error("device pulling at start");

	property p_stop_release;
		stop_seen |=> !dev_sda_oe [*4];
	endproperty
	a_stop_release: assert property (p_stop_release)
		else $error("device pulling after stop");

	property p_addr_match;
		rise && first_r && bit_cnt_r == 4'h8 |-> sda == (shift_r[7:1] != SLAVE_ADDR_MAIN);
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("address acknowledge wrong");

	property p_master_code;
		rise && first_r && bit_cnt_r == 4'h8 && shift_r[7:3] == 5'b00001 |-> sda;
	endproperty
	a_master_code: assert property (p_master_code)
		else $error("master code acknowledged");

	c_start: cover property (start_seen);
	c_stop: cover property (stop_seen);
	c_ack: cover property (rise && dev_sda_oe);
	c_code: cover property (rise && first_r && bit_cnt_r == 4'h8 && shift_r[7:3] == 5'b00001);
endmodule : charger_i2c_properties

/* dv/charger_i2c_register_port_bench.sv */
`timescale 1ns/1ps
module charger_i2c_register_port_bench;
	import charger_i2c_pkg::*;
	localparam logic [7:0] M_RD  = 8'h02;
	localparam logic [7:0] M_HS  = 8'h04;
	localparam logic [7:0] M_ALT = 8'h08;
	logic        mclk_i;
	logic        rst_n_i;
	logic [2:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [12:0] flag;
	logic [1:0]  chg_state;
	logic        boost_act;
	logic [2:0]  fault;
	logic [7:0]  charge_control;
	logic [7:0]  float_voltage;
	logic [7:0]  battery_current;
	logic [7:0]  special_charger;
	logic [7:0]  safety_limits;
	logic        stat_enable;
	logic        timer_reset;
	logic        hs_mode;
	logic        hs_seen;
	logic        tmr_seen;
	logic [7:0]  st;
	int          failures;
	int          checks;

	charger_i2c_if bus_if ();
	charger_i2c_host i_charger_i2c_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
	charger_i2c_device #(.ALT_ADDRESS(1'b0), .EXTENDED(1'b1)) i_charger_i2c_device (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .bus(bus_if), .termination_compare_flag_i(flag[0]), .near_zero_compare_i(flag[1]),
		.short_compare_i(flag[2]), .low_battery_compare_i(flag[3]), .boost_uvlo_compare_i(flag[4]),
		.linear_charge_flag_i(flag[5]), .over_temp_flag_i(flag[6]), .charge_loop_flag_i(flag[7]),
		.input_limit_flag_i(flag[8]), .input_present_flag_i(flag[9]), .constant_voltage_flag_i(flag[10]),
		.boosting_i(flag[11]), .otg_level_i(flag[12]), .charge_state_i(chg_state), .boost_active_i(boost_act),
		.fault_i(fault), .charge_control_o(charge_control), .float_voltage_o(float_voltage),
		.battery_current_o(battery_current), .special_charger_o(special_charger), .safety_limits_o(safety_limits),
		.stat_enable_o(stat_enable), .timer_reset_o(timer_reset), .hs_mode_o(hs_mode));
	charger_i2c_properties i_charger_i2c_properties (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl(bus_if.scl),
		.sda(bus_if.sda), .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe));

	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// Timer pulses are too short to poll through the port; the device high-speed flag is not on it
	always @(posedge mclk_i)
	begin
		if (hs_mode === 1'b1) hs_seen <= 1'b1;
		if (timer_reset === 1'b1) tmr_seen <= 1'b1;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic summarize;
		$display("Checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	// Extra edge after the strobe drops keeps back-to-back calls from double-driving it
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
		@(posedge mclk_i);
	endtask : bus_wr

	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
		@(negedge mclk_i);
		d = rdata;
		@(posedge mclk_i);
	endtask : bus_rd

	task automatic xfer(input logic [7:0] r, input logic [7:0] d, input logic [7:0] mode);
		int n;
		bus_wr(HOST_REG, r);
		bus_wr(HOST_WDATA, d);
		bus_wr(HOST_CTRL, mode | 8'h01);
		n = 0;
		st = 8'hFF;
		while (st[0] !== 1'b0 && n < 6000)
		begin
			bus_rd(HOST_STATUS, st);
			n++;
		end
		if (st[0] !== 1'b0)
		begin
			failures++;
			$display("Error busy expected 0 seen %b", st[0]);
			summarize();
		end
	endtask : xfer

	task automatic rd_reg(input string name, input logic [7:0] r, input logic [7:0] mode, input logic [7:0] exp);
		logic [7:0] v;
		xfer(r, 8'h00, mode | M_RD);
		bus_rd(HOST_RDATA, v);
		check(name, v, exp);
	endtask : rd_reg

	initial
	begin
		rst_n_i = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		flag = 13'h0000;
		chg_state = 2'b10;
		boost_act = 1'b1;
		fault = 3'b101;
		hs_seen = 1'b0;
		tmr_seen = 1'b0;
		failures = 0;
		checks = 0;
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		check("charge_control", charge_control, CHARGE_CONTROL_RST);
		check("float_voltage", float_voltage, FLOAT_VOLTAGE_RST);
		check("safety_limits", safety_limits, SAFETY_LIMITS_RST);
		check("stat_enable", {7'h00, stat_enable}, {7'h00, STAT_ENABLE_RST});
		bus_rd(3'h5, st);
		check("host_unmapped", st, 8'h00);
		xfer(REG_FLOAT_VOLTAGE, 8'hA5, 8'h00);
		check("write_nack", {7'h00, st[1]}, 8'h00);
		check("float_voltage", float_voltage, 8'hA5);
		rd_reg("float_read", REG_FLOAT_VOLTAGE, 8'h00, 8'hA5);
		xfer(REG_BATTERY_CURRENT, 8'h77, M_ALT);
		check("alt_nack", {7'h00, st[1]}, 8'h01);
		check("battery_current", battery_current, BATTERY_CURRENT_RST);
		xfer(REG_BATTERY_CURRENT, 8'h3C, M_HS);
		check("battery_current", battery_current, 8'h3C);
		check("hs_seen", {7'h00, hs_seen}, 8'h01);
		check("hs_after_stop", {7'h00, hs_mode}, 8'h00);
		xfer(REG_SPECIAL_CHARGER, 8'h5C, M_HS);
		xfer(REG_SAFETY_LIMITS, 8'h6E, M_HS);
		check("special_charger", special_charger, 8'h5C);
		check("safety_limits", safety_limits, 8'h6E);
		xfer(REG_DEVICE_IDENTITY, 8'hFF, M_HS);
		rd_reg("identity", REG_DEVICE_IDENTITY, M_HS, DEVICE_IDENTITY_VAL);
		rd_reg("unmapped", 8'h07, M_HS, UNMAPPED_READ);
		xfer(REG_STATUS_CONTROL, 8'h80, M_HS);
		check("timer_reset", {7'h00, tmr_seen}, 8'h01);
		check("stat_enable", {7'h00, stat_enable}, 8'h00);
		flag <= 13'h07A5;
		xfer(REG_CHARGE_CONTROL, 8'h38, M_HS);
		check("charge_control", charge_control, 8'h38);
		rd_reg("live_term", REG_LIVE_STATUS, M_HS, 8'hEF);
		flag <= 13'h03E5;
		xfer(REG_CHARGE_CONTROL, 8'h30, M_HS);
		rd_reg("live_near_zero", REG_LIVE_STATUS, M_HS, 8'h7E);
		flag <= 13'h13E5;
		xfer(REG_CHARGE_CONTROL, 8'h32, M_HS);
		rd_reg("live_high_z", REG_LIVE_STATUS, M_HS, 8'h3E);
		rd_reg("status_control", REG_STATUS_CONTROL, M_HS, 8'hAD);
		summarize();
	end
endmodule : charger_i2c_register_port_bench
